// file: ctl_model.sv
// Controller model: bus master that sends control and data words
`timescale 1ns/1ps
module ctl_model (
  // Clock and pacing
  input wire clock,
  input wire slow,
  // Write side
  output reg [7:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  // Read side
  output reg [7:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
  end
  // Released payloads show inverted data so stale values never look valid
  // Slow mode leaves one idle cycle before the request; bready stays up until the answer
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg aw, w, b;
    begin
      {aw, w, b} = 3'h7;
      @(posedge clock);
      if (slow) @(posedge clock);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
      s_axi_bready <= 1'b1;
      while (aw | w | b) begin
        @(posedge clock);
        if (aw && s_axi_awready) begin
          aw = 1'b0;
          {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
        end
        if (w && s_axi_wready) begin
          w = 1'b0;
          {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
        end
        if (b && s_axi_bvalid) begin
          b = 1'b0;
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
      end
    end
  endtask
  // Same pacing on reads; rready is raised with the address
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ar, rr;
    begin
      {ar, rr} = 2'h3;
      @(posedge clock);
      if (slow) @(posedge clock);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, 1'b1};
      while (ar | rr) begin
        @(posedge clock);
        if (ar && s_axi_arready) begin
          ar = 1'b0;
          {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        end
        if (rr && s_axi_rvalid) begin
          rr = 1'b0;
          {d, r} = {s_axi_rdata, s_axi_rresp};
          s_axi_rready <= 1'b0;
        end
      end
    end
  endtask
endmodule // ctl_model

// file: edge_card_map.vh
// Register offsets, field positions, reset values and timing counts of the edge event card
`ifndef EDGE_CARD_MAP_VH
`define EDGE_CARD_MAP_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_DATA 8'h08
`define OFS_RET 8'h0c
`define OFS_STAT 8'h10
`define OFS_ISTAT 8'h14
`define OFS_IMASK 8'h18

// Control word bits
`define CW_INPUT_SELECT 0
`define CW_SYS_OUT_EN 1
`define CW_INT_EN 2
`define CW_TIMING 3
`define CW_WIDTH 4

// Address cycle: gate bit
`define AD_GATE 0

// Return word: captured bits in 11:0, request bit above
`define NUM_CH 12
`define RET_IRQ 12

// Status bits
`define ST_ARMED 0
`define ST_FLAG 1
`define ST_ARM_PEND 2
`define ST_BYPASS 3

// Event bits (sticky status and mask share this layout)
`define EV_EDGE 0
`define EV_FLAG 1
`define EV_WIDTH 2

// Reset values
`define CTRL_RST 4'h0
`define IMASK_RST 2'h0

// Minimum persisting transition and clock rate
`define MIN_PULSE_NS 100
`define CLK_MHZ 40
`define FILT_CYC ((`MIN_PULSE_NS * `CLK_MHZ + 999) / 1000)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: edge_card_props.sv
// Checker for the edge card bus handshakes and flag line
`timescale 1ns/1ps
module edge_card_props (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Flag line
  input wire flag_ff,
  input wire flag_oe_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shared line only carries a request from an armed card
  property p_oe; flag_ff |-> flag_oe_ff; endproperty
  a_oe: assert property (p_oe) else $error("flag while undriven");
  property p_disarm; $fell(flag_oe_ff) |-> !flag_ff; endproperty
  a_disarm: assert property (p_disarm) else $error("flag after disarm");
  // Only a bus write may take a request away
  property p_hold; flag_ff && !s_axi_bvalid |=> flag_ff; endproperty
  a_hold: assert property (p_hold) else $error("request lost");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rkeep; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rkeep: assert property (p_rkeep) else $error("read data dropped");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  property p_bkeep; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bkeep: assert property (p_bkeep) else $error("response dropped");
  property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bref: assert property (p_bref) else $error("write taken early");
endmodule // edge_card_props

bind edge_event_interrupt_card edge_card_props u_props (
  .clock(clock), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .flag_ff(flag_ff), .flag_oe_ff(flag_oe_ff));

// file: edge_channel.v
// One input channel: persistence filter, rise and fall detectors, storage latch
`timescale 1ns/1ps
`include "edge_card_map.vh"

module edge_channel (
  // Clock and reset
  input wire clock,
  input wire rst_sync_n,
  // Pin and control
  input wire pin,
  input wire clr,
  // Results
  output reg captured_ff,
  output wire edge_seen
);

  reg stable_ff;
  reg primed_ff;
  reg [2:0] cnt_ff;
  reg [2:0] nxt_cnt;
  reg nxt_stable;
  wire rise;
  wire fall;
  // Last count before a new level is believed
  localparam [31:0] filt_last = `FILT_CYC - 1;

  // Level must differ for the full count before it is believed
  always @* begin
    nxt_cnt = 3'h0;
    nxt_stable = stable_ff;
    if (!primed_ff) begin
      nxt_stable = pin;
    end else if (pin != stable_ff) begin
      if (cnt_ff == filt_last[2:0]) begin
        nxt_stable = pin;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
  end

  // First sample after reset is taken as the level, not as an edge
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stable_ff <= 1'b0;
      primed_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else begin
      stable_ff <= nxt_stable;
      primed_ff <= 1'b1;
      cnt_ff <= nxt_cnt;
    end
  end

  // One rising and one falling detector per channel
  assign rise = primed_ff & nxt_stable & ~stable_ff;
  assign fall = primed_ff & ~nxt_stable & stable_ff;
  assign edge_seen = rise | fall;

  // New edge beats a clear in the same cycle, so nothing is lost
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      captured_ff <= 1'b0;
    end else begin
      captured_ff <= (captured_ff & ~clr) | edge_seen;
    end
  end

endmodule // edge_channel

// file: edge_event_interrupt_card.v
// Edge event interrupt card: twelve captured inputs, arming logic and AXI4-Lite registers
// Summary of operation
// - Twelve channels, each with rise and fall detector into one latch.
// - Transitions lasting at least 100 ns are detected and latched.
// - Armed card requests an interrupt once any detector has captured.
// - System output enable bit is stored but has no effect here.
// - With bypass jumper, interrupt enable plus timing control word arms alone.
// - Flag line is driven only while the card is armed.
// - Ungated address in input mode returns captured bits plus request bit.
// - Write-back of return word clears only those captured bits.
// - Edges arriving during or after the read stay captured on channels that were clear in the read word.
// - All-zero output-mode data word disarms; capture keeps running.
`timescale 1ns/1ps
`include "edge_card_map.vh"

module edge_event_interrupt_card (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Write address channel
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // Write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address channel
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // Read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Process inputs and jumper
  input wire [`NUM_CH-1:0] event_in,
  input wire arm_bypass_jumper,
  // Mainframe flag line and interrupt
  output reg flag_ff,
  output reg flag_oe_ff,
  output reg irq_ff
);

  reg [1:0] rst_sync_ff;
  wire rst_sync_n;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg [`CW_WIDTH-1:0] ctrl_ff;
  reg [`CW_WIDTH-1:0] nxt_ctrl;
  reg armed_ff;
  reg nxt_armed;
  reg arm_pend_ff;
  reg nxt_arm_pend;
  reg [`RET_IRQ:0] ret_ff;
  reg [`RET_IRQ:0] nxt_ret;
  reg [`EV_WIDTH-1:0] istat_ff;
  reg [`EV_WIDTH-1:0] imask_ff;
  reg [`EV_WIDTH-1:0] nxt_imask;
  reg [`EV_WIDTH-1:0] w1c;
  reg [`NUM_CH-1:0] clr_vec;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg wr_hit;
  wire [31:0] wmask;
  wire [31:0] wval;
  wire wr_fire;
  wire rd_fire;
  wire [`NUM_CH-1:0] captured;
  wire [`NUM_CH-1:0] edge_vec;
  wire any_capt;
  wire req;
  wire [`EV_WIDTH-1:0] ev_set;

  // Reset released through two flops; only the second copy is used
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // Twelve identical channels
  // Each filters its pin, detects both edges and keeps its own latch
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_ch
      edge_channel u_ch (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .pin(event_in[gi]),
        .clr(clr_vec[gi]),
        .captured_ff(captured[gi]),
        .edge_seen(edge_vec[gi])
      );
    end
  endgenerate

  // Latches keep capturing while disarmed; only the request is gated
  assign any_capt = |captured;
  // Request exists only when armed and something is latched
  assign req = armed_ff & any_capt;

  // Byte lanes from the write strobes
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                  {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign wval = w_data_ff & wmask;

  // Write fires once both address and data are held and no response waits
  // Both readies low already mark the halves held, so no extra state is kept
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  // Decode of the held write address
  always @* begin
    case (aw_addr_ff)
      `OFS_CTRL, `OFS_ADDR, `OFS_DATA, `OFS_RET,
      `OFS_STAT, `OFS_ISTAT, `OFS_IMASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Control word, arming, output data and address cycles
  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_armed = armed_ff;
    nxt_arm_pend = arm_pend_ff;
    nxt_ret = ret_ff;
    nxt_imask = imask_ff;
    clr_vec = {`NUM_CH{1'b0}};
    w1c = {`EV_WIDTH{1'b0}};
    if (wr_fire) begin
      case (aw_addr_ff)
        `OFS_CTRL: begin
          // System enable bit is kept for readback only
          nxt_ctrl = (ctrl_ff & ~wmask[`CW_WIDTH-1:0])
                     | wval[`CW_WIDTH-1:0];
          if (nxt_ctrl[`CW_INT_EN] && nxt_ctrl[`CW_TIMING] &&
              (arm_pend_ff || arm_bypass_jumper)) begin
            nxt_armed = 1'b1;
            nxt_arm_pend = 1'b0;
          end
        end
        `OFS_ADDR: begin
          if (ctrl_ff[`CW_INPUT_SELECT]) begin
            if (wval[`AD_GATE]) begin
              nxt_arm_pend = 1'b1;
            end else begin
              nxt_ret = {req, captured};
            end
          end
        end
        `OFS_DATA: begin
          // Input mode ignores data words
          // A zero word only disarms; capture itself never stops
          if (!ctrl_ff[`CW_INPUT_SELECT]) begin
            if (wval[`NUM_CH-1:0] == {`NUM_CH{1'b0}}) begin
              nxt_armed = 1'b0;
              nxt_arm_pend = 1'b0;
            end else begin
              clr_vec = wval[`NUM_CH-1:0];
            end
          end
        end
        `OFS_ISTAT: begin
          w1c = wval[`EV_WIDTH-1:0];
        end
        `OFS_IMASK: begin
          nxt_imask = (imask_ff & ~wmask[`EV_WIDTH-1:0])
                      | wval[`EV_WIDTH-1:0];
        end
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
  end

  // Control word register
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_ff <= `CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Arming state; a pending gate survives until arming or disarm
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      armed_ff <= 1'b0;
      arm_pend_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      arm_pend_ff <= nxt_arm_pend;
    end
  end

  // Return snapshot; held so later edges cannot alter a finished read
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ret_ff <= {(`RET_IRQ+1){1'b0}};
    end else begin
      ret_ff <= nxt_ret;
    end
  end

  // Interrupt mask
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      imask_ff <= `IMASK_RST;
    end else begin
      imask_ff <= nxt_imask;
    end
  end

  // Events: any new edge, and the flag request rising
  assign ev_set[`EV_EDGE] = |edge_vec;
  assign ev_set[`EV_FLAG] = req & ~flag_ff;

  // Sticky status; a set in the clearing cycle wins
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      istat_ff <= {`EV_WIDTH{1'b0}};
    end else begin
      istat_ff <= (istat_ff & ~w1c) | ev_set;
    end
  end

  // Flag line driven only while armed; the line is shared with other cards
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_ff <= 1'b0;
      flag_oe_ff <= 1'b0;
    end else begin
      flag_ff <= req;
      flag_oe_ff <= armed_ff;
    end
  end

  // Level interrupt from unmasked sticky status
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // Write address: taken once, reopened only after the response is taken
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_awready <= 1'b1;
      aw_addr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data: its own handshake, in either order against the address
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_wready <= 1'b1;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Response once both halves are held; unmapped offsets answer an error
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero with an error response
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL: rd_mux[`CW_WIDTH-1:0] = ctrl_ff;
      `OFS_ADDR: rd_mux = 32'h0000_0000;
      `OFS_DATA: rd_mux[`NUM_CH-1:0] = captured;
      `OFS_RET: rd_mux[`RET_IRQ:0] = ret_ff;
      `OFS_STAT: begin
        rd_mux[`ST_ARMED] = armed_ff;
        rd_mux[`ST_FLAG] = req;
        rd_mux[`ST_ARM_PEND] = arm_pend_ff;
        rd_mux[`ST_BYPASS] = arm_bypass_jumper;
      end
      `OFS_ISTAT: rd_mux[`EV_WIDTH-1:0] = istat_ff;
      `OFS_IMASK: rd_mux[`EV_WIDTH-1:0] = imask_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, answer the cycle after acceptance
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // edge_event_interrupt_card

// file: edge_event_interrupt_card_tb_top.sv
// Self-checking bench for the edge event card
`timescale 1ns/1ps
`include "edge_card_map.vh"
module edge_event_interrupt_card_tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [`NUM_CH-1:0] event_in = 12'h000;
  reg arm_bypass_jumper = 1'b0;
  reg slow = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, flag_ff, flag_oe_ff, irq_ff;
  integer failures = 0, total_checks = 0, cyc = 0, ch, k;
  reg [31:0] v;
  reg [1:0] r;
  always #12.5 clock = ~clock;
  edge_event_interrupt_card DUT (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .event_in(event_in), .arm_bypass_jumper(arm_bypass_jumper),
    .flag_ff(flag_ff), .flag_oe_ff(flag_oe_ff), .irq_ff(irq_ff));
  ctl_model m (
    .clock(clock), .slow(slow),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bus helpers with a random idle gap before each request
  task w(input [7:0] a, input [31:0] d);
    begin
      slow <= $urandom % 2;
      m.wr(a, d, r);
      chk({30'h0, r}, 32'h0);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      slow <= $urandom % 2;
      m.rd(a, v, r);
      chk(v, e);
    end
  endtask
  // Expected return word: request bit only for an armed card with a latch set
  function [31:0] ret_word(input armed, input [`NUM_CH-1:0] latches);
    begin
      ret_word = {19'h0, armed & (|latches), latches};
    end
  endfunction
  // Toggle an input for n cycles; under four it is put back as a glitch
  task flip(input integer c, input integer n);
    begin
      @(posedge clock);
      event_in[c] <= ~event_in[c];
      repeat (n) @(posedge clock);
      if (n < 4) event_in[c] <= ~event_in[c];
      repeat (6) @(posedge clock);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  initial begin
    v = $urandom(17);
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rc(`OFS_CTRL, 32'h0);
    m.rd(8'h1c, v, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    // Clear all latches, then a glitch and a boundary-length change
    w(`OFS_CTRL, 32'h2);
    // A gated address outside input mode must not mark arming
    w(`OFS_ADDR, 32'h1);
    rc(`OFS_STAT, 32'h0);
    w(`OFS_DATA, 32'hfff);
    rc(`OFS_DATA, 32'h0);
    ch = $urandom % 12;
    k = (ch + 1 + $urandom % 11) % 12;
    flip(k, 3);
    flip(ch, 4);
    rc(`OFS_DATA, 32'h1 << ch);
    chk({31'h0, flag_oe_ff}, 32'h0);
    // Gated arming with the jumper out
    w(`OFS_CTRL, 32'h1);
    w(`OFS_ADDR, 32'h1);
    w(`OFS_CTRL, 32'hc);
    repeat (2) @(posedge clock);
    chk({30'h0, flag_oe_ff, flag_ff}, 32'h3);
    // Read without gate, a late edge, then write back minus the request bit
    w(`OFS_CTRL, 32'h1);
    w(`OFS_ADDR, 32'h0);
    rc(`OFS_RET, ret_word(1'b1, 12'h1 << ch));
    flip(k, 4);
    w(`OFS_CTRL, 32'h2);
    w(`OFS_DATA, v & 32'hfff);
    rc(`OFS_DATA, 32'h1 << k);
    chk({31'h0, flag_ff}, 32'h1);
    // Zero word disarms while capture goes on
    w(`OFS_DATA, 32'h0);
    flip(ch, 4);
    chk({30'h0, flag_oe_ff, flag_ff}, 32'h0);
    rc(`OFS_DATA, (32'h1 << k) | (32'h1 << ch));
    // Disarmed card returns no request bit; input-mode data words are ignored
    w(`OFS_CTRL, 32'h3);
    w(`OFS_ADDR, 32'h0);
    rc(`OFS_RET, ret_word(1'b0, (12'h1 << k) | (12'h1 << ch)));
    w(`OFS_DATA, 32'hfff);
    rc(`OFS_DATA, (32'h1 << k) | (32'h1 << ch));
    m.wr(8'h1c, 32'h0, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    // Jumper arms from one control word
    arm_bypass_jumper <= 1'b1;
    w(`OFS_CTRL, 32'hc);
    rc(`OFS_STAT, 32'hb);
    // Sticky events, mask and clear
    rc(`OFS_IMASK, 32'h0);
    rc(`OFS_ISTAT, 32'h3);
    chk({31'h0, irq_ff}, 32'h0);
    w(`OFS_IMASK, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq_ff}, 32'h1);
    w(`OFS_ISTAT, 32'h3);
    repeat (2) @(posedge clock);
    chk({31'h0, irq_ff}, 32'h0);
    flip(k, 4);
    chk({31'h0, irq_ff}, 32'h1);
    end_sim;
  end
endmodule // edge_event_interrupt_card_tb_top
